/* File: core/pdt_pkg.sv */
// package: constants, types and register map of the pwm dead-time and adc trigger block
package pdt_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int TB_W = 13;
    localparam int DT_W = 12;
    localparam int POST_W = 4;
    localparam int DIV_W = 3;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFF_PRI_CTRL = 8'h00;
    localparam logic [7:0] OFF_SEV_CMP = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_GEN_BASE = 8'h10;
    localparam logic [7:0] GEN_STRIDE = 8'h10;
    localparam logic [7:0] GOFF_CTRL = 8'h00;
    localparam logic [7:0] GOFF_DTR = 8'h04;
    localparam logic [7:0] GOFF_ALTERNATE_DEAD_TIME_VALUE = 8'h08;
    localparam logic [7:0] GOFF_TRIG = 8'h0C;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTRL_DTC_LSB = 0;
    localparam int CTRL_INDEP_BIT = 2;
    localparam int CTRL_TRIGGER_IRQ_ENABLE_BIT = 3;
    localparam int CTRL_TRGDIV_LSB = 4;
    localparam int PRI_POST_LSB = 0;
    localparam int STAT_HIGH_LSB = 0;
    localparam int STAT_LOW_LSB = 4;
    localparam int STAT_POST_LSB = 12;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [POST_W-1:0] RST_POST = 4'h0;
    localparam logic [DIV_W-1:0] RST_DIV = 3'h0;
    localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        DTC_POS = 2'b00,
        DTC_NEG = 2'b01,
        DTC_OFF = 2'b10,
        DTC_OFF_ALT = 2'b11
    } pdt_dtc_e;

    typedef struct packed {
        pdt_dtc_e dtc;
        logic indep;
        logic trigger_irq_enable;
        logic [DIV_W-1:0] trgdiv;
        logic [DT_W-1:0] dtr;
        logic [DT_W-1:0] alternate_dead_time_value;
        logic [TB_W-1:0] trig;
    } pdt_gen_cfg_s;

endpackage

/* File: core/pdt_dead_time_unit.sv */
// dead-time unit: one complementary high/low pair with two coarse down counters
`timescale 1ns/1ps

module pdt_dead_time_unit (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // active pwm from the duty comparison
    input wire logic pwm_in,
    // configuration
    input wire pdt_pkg::pdt_dtc_e dtc,
    input wire logic indep,
    input wire logic [pdt_pkg::DT_W-1:0] dtr,
    input wire logic [pdt_pkg::DT_W-1:0] alternate_dead_time_value,
    // pair outputs, index 0 high side, 1 low side
    output logic high_out,
    output logic low_out,
    output logic fine_high,
    output logic fine_low
);

    typedef struct packed {
        logic prev;
        logic [1:0][pdt_pkg::DT_W-2:0] cnt;
        logic [1:0] out;
        logic [1:0] fine;
    } pdt_dtu_s;

    pdt_dtu_s st_r;
    pdt_dtu_s st_nxt;

    // ****************************************************************
    // edge detection and per-output delay
    // ****************************************************************
    always_comb begin
        logic edge_seen;
        logic [1:0] tgt;
        logic [1:0] delayed;
        logic [1:0][pdt_pkg::DT_W-1:0] val;
        edge_seen = 1'b0;
        tgt = 2'b00;
        delayed = 2'b00;
        val = '0;
        st_nxt = st_r;
        st_nxt.prev = pwm_in;
        edge_seen = pwm_in ^ st_r.prev;
        tgt[0] = pwm_in;
        tgt[1] = indep ? pwm_in : ~pwm_in;
        val[0] = dtr;
        val[1] = alternate_dead_time_value;
        for (int i = 0; i < 2; i++) begin
            // positive dead time delays turn-on, negative delays turn-off
            delayed[i] = ((dtc == pdt_pkg::DTC_POS) && tgt[i]) ||
                         ((dtc == pdt_pkg::DTC_NEG) && !tgt[i]);
            if (edge_seen && delayed[i]) begin
                st_nxt.cnt[i] = val[i][pdt_pkg::DT_W-1:1];
                st_nxt.fine[i] = val[i][0];
                if (val[i][pdt_pkg::DT_W-1:1] == '0) begin
                    st_nxt.out[i] = tgt[i];
                end
            end else if (st_r.cnt[i] != '0) begin
                // count down one step per clock, switch when zero is reached
                st_nxt.cnt[i] = st_r.cnt[i] - 1'b1;
                if (st_r.cnt[i] == 11'h001) begin
                    st_nxt.out[i] = tgt[i];
                end
            end else begin
                // undelayed edge, disabled dead time or mode change
                st_nxt.out[i] = tgt[i];
                if (edge_seen) begin
                    st_nxt.fine[i] = 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign high_out = st_r.out[0];
    assign low_out = st_r.out[1];
    assign fine_high = st_r.fine[0];
    assign fine_low = st_r.fine[1];

endmodule

/* File: core/pdt_pwm_dead_time_trigger.sv */
// top: register port, dead-time pairs, special event trigger and per-generator adc triggers
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps

// Contract
// - an output stays off until its complement has been off for the dead time
// - alternate dead-time value applies to the complementary (low) output
// - dead time is available for every pair in any output mode
// - optional negative dead time overlaps high and low for the interval
// - two-bit per-generator field selects positive, negative or no dead time
// - each pair has 12-bit down counters and rise/fall detectors on duty output; the code's counters are 11-bit (value[11:1])
// - on a duty edge the relevant transition waits until its counter reaches zero
// - dead-time values are 12-bit unsigned, counters step at the 4x rate
// - the dead-time least significant bit goes to fine-adjust logic, not the counter
// - special event trigger fires when primary count equals its compare value
// - special event pulses are always produced, there is no enable
// - four-bit postscaler divides special event output from 1:1 to 1:16
// - postscaler count clears on any compare write and on reset
// - each generator triggers the adc when local count equals its match value
// - match values above the local period never trigger
// - with trigger irq enable set every trigger event raises an interrupt request
// - three-bit divider issues the adc trigger once per 1 to 7 events; the code's settings 0 to 7 give once per 1 to 8 events
// - in complementary mode low output is the inverse of the active pwm
// - independent local counter counts to its phase value, defining the period
module pdt_pwm_dead_time_trigger #(
    parameter int NGEN = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [pdt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pdt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pdt_pkg::DATA_W-1:0] reg_rdata,
    // time bases and duty comparison from the rest of the pwm module
    input wire logic [pdt_pkg::TB_W-1:0] primary_timebase_count,
    input wire logic [NGEN-1:0] duty_active,
    input wire logic [NGEN-1:0][pdt_pkg::TB_W-1:0] local_count,
    input wire logic [NGEN-1:0][pdt_pkg::TB_W-1:0] local_period,
    // gate driver pins
    output logic [NGEN-1:0] high_side_output,
    output logic [NGEN-1:0] low_side_output,
    output logic [NGEN-1:0] fine_adjust_high,
    output logic [NGEN-1:0] fine_adjust_low,
    // adc and interrupt requests
    output logic special_event_trigger,
    output logic [NGEN-1:0] adc_trigger,
    output logic [NGEN-1:0] trigger_irq
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    // the status word holds at most four generators; the address map has room for more
    if (NGEN < 1 || NGEN > 4) begin : g_bad_ngen
        $error("NGEN must lie between 1 and 4");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [pdt_pkg::POST_W-1:0] post;
        logic [pdt_pkg::TB_W-1:0] sevcmp;
        pdt_pkg::pdt_gen_cfg_s [NGEN-1:0] gen;
        logic sev_hit;
        logic [pdt_pkg::POST_W-1:0] sev_cnt;
        logic sev_pulse;
        logic [NGEN-1:0] trg_hit;
        logic [NGEN-1:0][pdt_pkg::DIV_W-1:0] trg_cnt;
        logic [NGEN-1:0] adc;
        logic [NGEN-1:0] irq;
        logic [pdt_pkg::DATA_W-1:0] rdata;
    } pdt_state_s;

    pdt_state_s st_r;
    pdt_state_s st_nxt;
    logic [NGEN-1:0] high_w;
    logic [NGEN-1:0] low_w;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // byte address of a per-generator register
    function automatic logic [pdt_pkg::ADDR_W-1:0] gen_addr(input int g, input logic [7:0] off);
        logic [31:0] a;
        a = 32'(pdt_pkg::OFF_GEN_BASE) + 32'(g) * 32'(pdt_pkg::GEN_STRIDE) + 32'(off);
        return a[pdt_pkg::ADDR_W-1:0];
    endfunction

    // divider step: count events, pass one when the count reaches the setting
    function automatic logic div_pass(input logic [3:0] cnt, input logic [3:0] setting);
        return cnt >= setting;
    endfunction

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        logic sev_now;
        logic trg_now;
        logic [pdt_pkg::DATA_W-1:0] rd_val;
        sev_now = 1'b0;
        trg_now = 1'b0;
        rd_val = pdt_pkg::RST_DATA;
        st_nxt = st_r;
        st_nxt.sev_pulse = 1'b0;
        st_nxt.adc = '0;
        st_nxt.irq = '0;

        // special event: fire on entry into the compare match, no enable bit
        sev_now = (primary_timebase_count == st_r.sevcmp);
        st_nxt.sev_hit = sev_now;
        if (sev_now && !st_r.sev_hit) begin
            if (div_pass(st_r.sev_cnt, st_r.post)) begin
                st_nxt.sev_pulse = 1'b1;
                st_nxt.sev_cnt = pdt_pkg::RST_POST;
            end else begin
                st_nxt.sev_cnt = st_r.sev_cnt + 1'b1;
            end
        end

        // individual triggers against each local time base
        for (int g = 0; g < NGEN; g++) begin
            // period input is the wrap (phase) value
            trg_now = (local_count[g] == st_r.gen[g].trig) &&
                      (st_r.gen[g].trig <= local_period[g]);
            st_nxt.trg_hit[g] = trg_now;
            if (trg_now && !st_r.trg_hit[g]) begin
                st_nxt.irq[g] = st_r.gen[g].trigger_irq_enable;
                if (div_pass({1'b0, st_r.trg_cnt[g]}, {1'b0, st_r.gen[g].trgdiv})) begin
                    st_nxt.adc[g] = 1'b1;
                    st_nxt.trg_cnt[g] = pdt_pkg::RST_DIV;
                end else begin
                    st_nxt.trg_cnt[g] = st_r.trg_cnt[g] + 1'b1;
                end
            end
        end

        // register writes
        if (reg_wr) begin
            if (reg_addr == pdt_pkg::OFF_PRI_CTRL) begin
                st_nxt.post = reg_wdata[pdt_pkg::PRI_POST_LSB +: pdt_pkg::POST_W];
            end else if (reg_addr == pdt_pkg::OFF_SEV_CMP) begin
                st_nxt.sevcmp = reg_wdata[pdt_pkg::TB_W-1:0];
                // a compare write restarts the postscaler, even over an event
                st_nxt.sev_cnt = pdt_pkg::RST_POST;
            end else begin
                for (int g = 0; g < NGEN; g++) begin
                    if (reg_addr == gen_addr(g, pdt_pkg::GOFF_CTRL)) begin
                        st_nxt.gen[g].dtc = pdt_pkg::pdt_dtc_e'(reg_wdata[pdt_pkg::CTRL_DTC_LSB +: 2]);
                        st_nxt.gen[g].indep = reg_wdata[pdt_pkg::CTRL_INDEP_BIT];
                        st_nxt.gen[g].trigger_irq_enable = reg_wdata[pdt_pkg::CTRL_TRIGGER_IRQ_ENABLE_BIT];
                        st_nxt.gen[g].trgdiv = reg_wdata[pdt_pkg::CTRL_TRGDIV_LSB +: pdt_pkg::DIV_W];
                    end else if (reg_addr == gen_addr(g, pdt_pkg::GOFF_DTR)) begin
                        st_nxt.gen[g].dtr = reg_wdata[pdt_pkg::DT_W-1:0];
                    end else if (reg_addr == gen_addr(g, pdt_pkg::GOFF_ALTERNATE_DEAD_TIME_VALUE)) begin
                        st_nxt.gen[g].alternate_dead_time_value = reg_wdata[pdt_pkg::DT_W-1:0];
                    end else if (reg_addr == gen_addr(g, pdt_pkg::GOFF_TRIG)) begin
                        st_nxt.gen[g].trig = reg_wdata[pdt_pkg::TB_W-1:0];
                    end
                end
            end
        end

        // register reads, unmapped addresses answer zero
        if (reg_addr == pdt_pkg::OFF_PRI_CTRL) begin
            rd_val[pdt_pkg::PRI_POST_LSB +: pdt_pkg::POST_W] = st_r.post;
        end else if (reg_addr == pdt_pkg::OFF_SEV_CMP) begin
            rd_val[pdt_pkg::TB_W-1:0] = st_r.sevcmp;
        end else if (reg_addr == pdt_pkg::OFF_STATUS) begin
            rd_val[pdt_pkg::STAT_HIGH_LSB +: NGEN] = high_w;
            rd_val[pdt_pkg::STAT_LOW_LSB +: NGEN] = low_w;
            rd_val[pdt_pkg::STAT_POST_LSB +: pdt_pkg::POST_W] = st_r.sev_cnt;
        end else begin
            for (int g = 0; g < NGEN; g++) begin
                if (reg_addr == gen_addr(g, pdt_pkg::GOFF_CTRL)) begin
                    rd_val[pdt_pkg::CTRL_DTC_LSB +: 2] = st_r.gen[g].dtc;
                    rd_val[pdt_pkg::CTRL_INDEP_BIT] = st_r.gen[g].indep;
                    rd_val[pdt_pkg::CTRL_TRIGGER_IRQ_ENABLE_BIT] = st_r.gen[g].trigger_irq_enable;
                    rd_val[pdt_pkg::CTRL_TRGDIV_LSB +: pdt_pkg::DIV_W] = st_r.gen[g].trgdiv;
                end else if (reg_addr == gen_addr(g, pdt_pkg::GOFF_DTR)) begin
                    rd_val[pdt_pkg::DT_W-1:0] = st_r.gen[g].dtr;
                end else if (reg_addr == gen_addr(g, pdt_pkg::GOFF_ALTERNATE_DEAD_TIME_VALUE)) begin
                    rd_val[pdt_pkg::DT_W-1:0] = st_r.gen[g].alternate_dead_time_value;
                end else if (reg_addr == gen_addr(g, pdt_pkg::GOFF_TRIG)) begin
                    rd_val[pdt_pkg::TB_W-1:0] = st_r.gen[g].trig;
                end
            end
        end
        // read data stands only in the cycle after the strobe
        st_nxt.rdata = reg_rd ? rd_val : pdt_pkg::RST_DATA;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // reset clears configuration and the postscaler count alike
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // dead-time pairs
    // ****************************************************************
    // one unit per generator so every pair gets dead time whatever its mode
    for (genvar g = 0; g < NGEN; g++) begin : g_dt
        pdt_dead_time_unit u_dt (
            .clk(clk),
            .srst(srst),
            .pwm_in(duty_active[g]),
            .dtc(st_r.gen[g].dtc),
            .indep(st_r.gen[g].indep),
            .dtr(st_r.gen[g].dtr),
            .alternate_dead_time_value(st_r.gen[g].alternate_dead_time_value),
            .high_out(high_w[g]),
            .low_out(low_w[g]),
            .fine_high(fine_adjust_high[g]),
            .fine_low(fine_adjust_low[g])
        );
    end

    // ****************************************************************
    // outputs, all from flip-flops
    // ****************************************************************
    assign high_side_output = high_w;
    assign low_side_output = low_w;
    assign special_event_trigger = st_r.sev_pulse;
    assign adc_trigger = st_r.adc;
    assign trigger_irq = st_r.irq;
    assign reg_rdata = st_r.rdata;

endmodule

/* File: tb/pdt_checker.sv */
// checker: cause and timing of the pair outputs and trigger pulses
`timescale 1ns/1ps
module pdt_checker #(
    parameter int NGEN = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register writes
    input wire logic [pdt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pdt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    // time bases and duty
    input wire logic [pdt_pkg::TB_W-1:0] primary_timebase_count,
    input wire logic [NGEN-1:0] duty_active,
    input wire logic [NGEN-1:0][pdt_pkg::TB_W-1:0] local_count,
    input wire logic [NGEN-1:0][pdt_pkg::TB_W-1:0] local_period,
    // outputs
    input wire logic [NGEN-1:0] high_side_output,
    input wire logic [NGEN-1:0] low_side_output,
    input wire logic [NGEN-1:0] fine_adjust_high,
    input wire logic special_event_trigger,
    input wire logic [NGEN-1:0] adc_trigger,
    input wire logic [NGEN-1:0] trigger_irq
);
    logic [15:0] ctrl_r, dtr_r, trig_r, cmp_r;
    logic pos, neg;
    // shadows of generator 0 and the compare
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r <= 16'h0000;
            dtr_r <= 16'h0000;
            trig_r <= 16'h0000;
            cmp_r <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                8'h04: cmp_r <= reg_wdata;
                8'h10: ctrl_r <= reg_wdata;
                8'h14: dtr_r <= reg_wdata;
                8'h1C: trig_r <= reg_wdata;
                default: ;
            endcase
        end
    end
    // complementary pairs only
    assign pos = ctrl_r[2:0] == 3'h0;
    assign neg = ctrl_r[2:0] == 3'h1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_gap; pos |-> !(high_side_output[0] && low_side_output[0]); endproperty
    a_gap: assert property (p_gap) else $error("pair on together in positive mode");
    property p_overlap; neg |-> (high_side_output[0] || low_side_output[0]); endproperty
    a_overlap: assert property (p_overlap) else $error("pair off together in negative mode");
    property p_fall; pos && $fell(high_side_output[0]) |-> !$past(duty_active[0]) && $past(duty_active[0], 2);
    endproperty
    a_fall: assert property (p_fall) else $error("high turn-off not tied to duty fall");
    property p_fine; pos && $rose(high_side_output[0]) |-> fine_adjust_high[0] == dtr_r[0]; endproperty
    a_fine: assert property (p_fine) else $error("fine adjust bit differs from value lsb");
    property p_sev; special_event_trigger |-> $past(primary_timebase_count) == $past(cmp_r[12:0]); endproperty
    a_sev: assert property (p_sev) else $error("special event without compare match");
    property p_trg;
        adc_trigger[0] |-> $past(local_count[0]) == $past(trig_r[12:0]) && $past(trig_r[12:0]) <= $past(local_period[0]);
    endproperty
    a_trg: assert property (p_trg) else $error("adc trigger without valid match");
    property p_irq; trigger_irq[0] |-> $past(ctrl_r[3]) && $past(local_count[0]) == $past(trig_r[12:0]); endproperty
    a_irq: assert property (p_irq) else $error("trigger irq without enable or match");
    property p_div0; trigger_irq[0] && $past(ctrl_r[6:4]) == 3'h0 |-> adc_trigger[0]; endproperty
    a_div0: assert property (p_div0) else $error("divider zero dropped an event");
    c_sev: cover property (special_event_trigger);
    c_trg: cover property (adc_trigger[0]);
    c_rise: cover property (pos && $rose(high_side_output[0]));
endmodule

/* File: tb/pdt_adc_model.sv */
// far-side model: gate drivers of pair 0 and the adc, counting what they receive
`timescale 1ns/1ps
module pdt_adc_model #(
    parameter int NGEN = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // gate drives of pair 0
    input wire logic high_side_output,
    input wire logic low_side_output,
    // adc trigger inputs
    input wire logic special_event_trigger,
    input wire logic [NGEN-1:0] adc_trigger,
    // counts seen so far
    output int sev_count,
    output int adc_count [NGEN],
    output int overlap_count
);
    // one conversion per pulse; both drives on is shoot-through, counted per cycle
    always @(posedge clk) begin
        if (srst) begin
            sev_count <= 0;
            overlap_count <= 0;
            foreach (adc_count[g]) adc_count[g] <= 0;
        end else begin
            sev_count <= sev_count + int'(special_event_trigger);
            overlap_count <= overlap_count + int'(high_side_output && low_side_output);
            foreach (adc_count[g]) adc_count[g] <= adc_count[g] + int'(adc_trigger[g]);
        end
    end
endmodule

/* File: tb/pdt_pwm_dead_time_trigger_tb.sv */
// testbench: dead time, special event and adc trigger scenarios on the block top
`timescale 1ns/1ps
module pdt_pwm_dead_time_trigger_tb;
    // ********
    // signals
    // ********
    localparam int NG = 2;
    typedef struct {logic [2:0] dtc; logic [11:0] dtr; logic [11:0] alt; int hon, loff, hoff, lon, ovl;}
        pdt_row_s;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [12:0] ptc = 13'h0000;
    logic [NG-1:0] duty = '0;
    logic [NG-1:0][12:0] lc = '0;
    logic [NG-1:0][12:0] lp = {2{13'h0014}};
    logic [NG-1:0] high, low, fh, fl, adc, irq;
    logic sev;
    int sev_cnt, ovl_cnt, th, tl, n, m, q;
    int adc_cnt [NG];
    int irq_cnt [NG] = '{0, 0};
    int miscompares = 0;
    int checks_done = 0;
    // edges to switch: one undelayed, value[11:1] plus one delayed, 0 if never; last row independent
    pdt_row_s rows [6] = '{'{3'b000, 12'h006, 12'h00A, 4, 1, 1, 6, 0}, '{3'b000, 12'h007, 12'h003, 4, 1, 1, 2, 0},
        '{3'b000, 12'h000, 12'h001, 1, 1, 1, 1, 0}, '{3'b001, 12'h004, 12'h008, 1, 5, 3, 1, 6},
        '{3'b010, 12'h006, 12'h006, 1, 1, 1, 1, 0}, '{3'b111, 12'h006, 12'h006, 1, 0, 1, 0, 31}};
    // clock and irq counting; the interrupt controller is not modelled
    always #4 clk = ~clk;
    always @(posedge clk) foreach (irq_cnt[g]) irq_cnt[g] += int'(irq[g] === 1'b1);
    // ********
    // instances
    // ********
    pdt_pwm_dead_time_trigger #(.NGEN(NG)) u_pdt_pwm_dead_time_trigger (.clk, .srst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .primary_timebase_count(ptc), .duty_active(duty), .local_count(lc),
        .local_period(lp), .high_side_output(high), .low_side_output(low), .fine_adjust_high(fh),
        .fine_adjust_low(fl), .special_event_trigger(sev), .adc_trigger(adc), .trigger_irq(irq));
    pdt_adc_model #(.NGEN(NG)) u_pdt_adc_model (.clk, .srst, .high_side_output(high[0]), .low_side_output(low[0]),
        .special_event_trigger(sev), .adc_trigger(adc), .sev_count(sev_cnt), .adc_count(adc_cnt),
        .overlap_count(ovl_cnt));
    // ********
    // tasks
    // ********
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h got %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(name, exp, reg_rdata);
    endtask
    // one duty edge; first edge at which each output switches
    task automatic meas(input logic lvl, output int h, output int l);
        @(posedge clk);
        duty[0] <= lvl;
        h = 0;
        l = 0;
        for (int k = 1; k <= 30; k++) begin
            @(posedge clk);
            #1;
            if (h == 0 && high[0] === lvl) h = k;
            if (l == 0 && low[0] === !lvl) l = k;
        end
    endtask
    // primary count ramps over the compare value once per event
    task automatic sev_ev(input int cnt);
        for (int k = 0; k < cnt * 5; k++) begin
            @(posedge clk);
            ptc <= 13'(98 + k % 5);
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic trg_ev(input int cnt, input int top);
        for (int k = 0; k < cnt * (top + 1); k++) begin
            @(posedge clk);
            lc <= {2{13'(k % (top + 1))}};
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ********
    // sequence
    // ********
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            wr(8'h14, {4'h0, rows[i].dtr});
            wr(8'h18, {4'h0, rows[i].alt});
            wr(8'h10, {13'h0000, rows[i].dtc});
            q = ovl_cnt;
            meas(1'b1, th, tl);
            check("high on", 16'(rows[i].hon), 16'(th));
            check("low off", 16'(rows[i].loff), 16'(tl));
            meas(1'b0, th, tl);
            check("high off", 16'(rows[i].hoff), 16'(th));
            check("low on", 16'(rows[i].lon), 16'(tl));
            check("fine low", 16'(rows[i].dtc == 3'b000 && rows[i].alt[0]), 16'(fl[0]));
            check("overlap", 16'(rows[i].ovl), 16'(ovl_cnt - q));
            $display("dead time row %0d done", i);
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 16'(i * 5 % 16));
            wr(8'h04, 16'h0064);
            n = sev_cnt;
            sev_ev(2 * (i * 5 % 16 + 1));
            check("special events", 16'h0002, 16'(sev_cnt - n));
        end
        wr(8'h00, 16'h0002);
        n = sev_cnt;
        sev_ev(2);
        wr(8'h04, 16'h0064);
        sev_ev(2);
        check("postscale cleared", 16'h0000, 16'(sev_cnt - n));
        sev_ev(1);
        check("event after clear", 16'h0001, 16'(sev_cnt - n));
        $display("special event test done");
        wr(8'h1C, 16'h000A);
        wr(8'h2C, 16'h000A);
        for (int k = 0; k <= 6; k++) begin
            wr(8'h10, 16'(8 + k * 16));
            wr(8'h20, 16'(k * 16));
            n = adc_cnt[0];
            m = adc_cnt[1];
            q = irq_cnt[0];
            th = irq_cnt[1];
            trg_ev(2 * (k + 1), 12);
            check("adc gen0", 16'h0002, 16'(adc_cnt[0] - n));
            check("adc gen1", 16'h0002, 16'(adc_cnt[1] - m));
            check("irq gen0", 16'(2 * (k + 1)), 16'(irq_cnt[0] - q));
            check("irq gen1", 16'h0000, 16'(irq_cnt[1] - th));
        end
        wr(8'h10, 16'h0008);
        wr(8'h1C, 16'h0019);
        n = adc_cnt[0];
        trg_ev(2, 30);
        check("match above period", 16'h0000, 16'(adc_cnt[0] - n));
        wr(8'h1C, 16'h0014);
        trg_ev(2, 30);
        check("match at period", 16'h0002, 16'(adc_cnt[0] - n));
        $display("adc trigger test done");
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(8'h14, 16'h0000, "dead time reset");
        rd(8'h04, 16'h0000, "compare reset");
        check("low after reset", 16'h0001, {15'h0000, low[0]});
        check("high after reset", 16'h0000, {15'h0000, high[0]});
        wr(8'h14, 16'hFFFF);
        rd(8'h14, 16'h0FFF, "dead time width");
        wr(8'h0C, 16'h1234);
        rd(8'h0C, 16'h0000, "unmapped read");
        $display("reset and register test done");
        test_done();
    end
    // watchdog against a hung sequence
    initial begin
        #400000;
        miscompares++;
        test_done();
    end
endmodule

bind pdt_pwm_dead_time_trigger pdt_checker #(.NGEN(NGEN)) u_pdt_checker (.clk, .srst, .reg_addr, .reg_wdata,
    .reg_wr, .primary_timebase_count, .duty_active, .local_count, .local_period, .high_side_output,
    .low_side_output, .fine_adjust_high, .special_event_trigger, .adc_trigger, .trigger_irq);
